// file: hw/rgac_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rgac_map.svh"
// Summary of operation
// [RULE1] manual or automatic mode, software selected
// [RULE2] automatic mode regulates attenuation without software
// [RULE3] reads LNA and TIA comparator pairs
// [RULE4] front-end attenuator: 18 steps of 2 dB
// [RULE5] baseband attenuator: 15 steps of 2 dB
// [RULE6] first steps go to baseband attenuator
// [RULE7] above takeover, steps go to front end
// [RULE8] front end full, rest back to baseband
// [RULE9] takeover threshold is software writable
// [RULE10] request maps to shares summing to total
// [RULE11] applied attenuation reported downstream
// [RULE12] overload up one step, underload down one
// [RULE13] manual mode uses software values, ignores detectors
module rgac_top (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // avalon-mm slave
    input  wire logic [3:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output var  logic [31:0]           avs_readdata,
    output var  logic                  avs_waitrequest,
    // peak detectors
    input  wire rgac_pkg::rgac_det_s   lna_det,
    input  wire rgac_pkg::rgac_det_s   tia_det,
    // attenuator drive
    output var  rgac_pkg::rgac_step_t  front_end_attenuation,
    output var  rgac_pkg::rgac_step_t  baseband_attenuation,
    // downstream report, total in dB
    output var  logic [7:0]            applied_atten_db
);
    import rgac_pkg::*;

    // ==========================================================
    // state
    rgac_mode_e  mode_r;              // operating mode
    rgac_req_t   takeover_r;          // takeover threshold
    rgac_step_t  man_fe_r;            // manual front-end setting
    rgac_step_t  man_bb_r;            // manual baseband setting
    rgac_req_t   req_r;               // requested total
    rgac_req_t   req_nxt;             // next requested total
    rgac_att_s   split_att;           // split of request
    logic        ack_r;               // bus answer cycle
    logic        any_over;            // some detector overloaded
    logic        any_under;           // all detectors underloaded

    // clip a written value to a limit
    function automatic rgac_step_t clip5(input logic [4:0] v, input logic [4:0] lim);
        clip5 = (v > lim) ? lim : v;
    endfunction : clip5

    // write strobe of one register, taken on the answer cycle only
    // one decode shared by every register write
    function automatic logic wr_hit(input logic [3:0] off);
        wr_hit = avs_write & ack_r & (avs_address == off);
    endfunction : wr_hit

    // ==========================================================
    // bus handshake: one wait cycle, then answer
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

    // ==========================================================
    // mode register
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r <= RGAC_MANUAL;
        end else if (wr_hit(`RGAC_OFF_CTRL) && avs_byteenable[0]) begin
            // bit selects automatic regulation
            mode_r <= avs_writedata[`RGAC_CTRL_AUTO_BIT] ? RGAC_AUTO : RGAC_MANUAL; // RULE1
        end
    end

    // ==========================================================
    // takeover threshold
    always_ff @(posedge clk) begin
        if (rst) begin
            takeover_r <= `RGAC_TAKEOVER_RST;
        end else if (wr_hit(`RGAC_OFF_TAKEOVER) && avs_byteenable[0]) begin
            takeover_r <= avs_writedata[5:0];                      // RULE9
        end
    end

    // ==========================================================
    // manual settings, clipped to each attenuator range
    always_ff @(posedge clk) begin
        if (rst) begin
            man_fe_r <= 5'h00;
            man_bb_r <= 5'h00;
        end else if (wr_hit(`RGAC_OFF_MANUAL)) begin
            if (avs_byteenable[0]) begin
                man_fe_r <= clip5(avs_writedata[`RGAC_MAN_FE_LSB +: 5], `RGAC_FE_MAX); // RULE4
            end
            if (avs_byteenable[1]) begin
                man_bb_r <= clip5(avs_writedata[`RGAC_MAN_BB_LSB +: 5], `RGAC_BB_MAX); // RULE5
            end
        end
    end

    // ==========================================================
    // detector evaluation
    always_comb begin
        any_over  = lna_det.over | tia_det.over;                   // RULE3
        any_under = lna_det.under & tia_det.under;
    end

    // ==========================================================
    // request stepping
    always_comb begin
        req_nxt = req_r;
        unique case (mode_r)
            RGAC_AUTO: begin
                if (any_over) begin
                    // overload wins, step up, saturate
                    if (req_r < `RGAC_REQ_MAX) begin
                        req_nxt = req_r + 6'h01;                  // RULE12
                    end
                end else if (any_under) begin
                    if (req_r != 6'h00) begin
                        req_nxt = req_r - 6'h01;                  // RULE12
                    end
                end
            end
            RGAC_MANUAL: begin
                // detectors ignored
                req_nxt = req_r;                                  // RULE13
            end
            default: req_nxt = req_r;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            req_r <= 6'h00;
        end else begin
            req_r <= req_nxt;                                      // RULE2
        end
    end

    // ==========================================================
    // split request into two shares
    rgac_split u_split (
        .req      (req_r),
        .takeover (takeover_r),
        .att      (split_att)                                      // RULE10
    );

    // ==========================================================
    // attenuator outputs, registered
    always_ff @(posedge clk) begin
        if (rst) begin
            front_end_attenuation <= 5'h00;
            baseband_attenuation  <= 5'h00;
        end else if (mode_r == RGAC_AUTO) begin
            front_end_attenuation <= split_att.fe;                 // RULE2
            baseband_attenuation  <= split_att.bb;
        end else begin
            front_end_attenuation <= man_fe_r;                     // RULE13
            baseband_attenuation  <= man_bb_r;
        end
    end

    // ==========================================================
    // applied total in dB for signal-strength correction
    always_ff @(posedge clk) begin
        if (rst) begin
            applied_atten_db <= 8'h00;
        end else begin
            applied_atten_db <= 8'(({3'h0, front_end_attenuation} + {3'h0, baseband_attenuation})
                                   * `RGAC_STEP_DB);                // RULE11
        end
    end

    // ==========================================================
    // read data, registered in the first (wait) cycle, ready for the answer
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            avs_readdata <= 32'h0000_0000;
            case (avs_address)
                `RGAC_OFF_CTRL:     avs_readdata[`RGAC_CTRL_AUTO_BIT] <= (mode_r == RGAC_AUTO);
                `RGAC_OFF_TAKEOVER: avs_readdata[5:0] <= takeover_r;
                `RGAC_OFF_MANUAL: begin
                    avs_readdata[`RGAC_MAN_FE_LSB +: 5] <= man_fe_r;
                    avs_readdata[`RGAC_MAN_BB_LSB +: 5] <= man_bb_r;
                end
                `RGAC_OFF_STATUS: begin
                    avs_readdata[`RGAC_ST_FE_LSB +: 5]  <= front_end_attenuation; // RULE11
                    avs_readdata[`RGAC_ST_BB_LSB +: 5]  <= baseband_attenuation;
                    avs_readdata[`RGAC_ST_REQ_LSB +: 6] <= req_r;
                    avs_readdata[`RGAC_ST_AUTO_BIT]     <= (mode_r == RGAC_AUTO);
                end
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // checks: sequences shared by the properties below
    // first cycle of an access, before any answer
    sequence s_bus_first;
        (avs_read || avs_write) && !ack_r;
    endsequence
    // an access still held one cycle later
    sequence s_bus_held;
        s_bus_first ##1 (avs_read || avs_write);
    endsequence
    // overload seen with room left above
    sequence s_over_room;
        (mode_r == RGAC_AUTO) && any_over && (req_r < `RGAC_REQ_MAX);
    endsequence
    // underload alone with room left below
    sequence s_under_room;
        (mode_r == RGAC_AUTO) && !any_over && any_under && (req_r != 6'h00);
    endsequence
    // two manual cycles in a row
    sequence s_manual_run;
        (mode_r == RGAC_MANUAL) ##1 (mode_r == RGAC_MANUAL);
    endsequence
    // control write taken on the answer edge, lane 0 enabled
    sequence s_ctrl_taken;
        avs_write && ack_r && (avs_address == `RGAC_OFF_CTRL) && avs_byteenable[0];
    endsequence
    // takeover write taken on the answer edge, lane 0 enabled
    sequence s_tko_taken;
        avs_write && ack_r && (avs_address == `RGAC_OFF_TAKEOVER) && avs_byteenable[0];
    endsequence
    // status read in the first cycle of the access
    sequence s_status_read;
        avs_read && !ack_r && (avs_address == `RGAC_OFF_STATUS);
    endsequence

    // ==========================================================
    // checks: ranges and codes
    // front end never beyond its last step
    a_fe_range: assert property (@(posedge clk) disable iff (rst) // RULE4
        front_end_attenuation <= `RGAC_FE_MAX)
        else $error("front-end attenuation out of range");
    // baseband never beyond its last step
    a_bb_range: assert property (@(posedge clk) disable iff (rst) // RULE5
        baseband_attenuation <= `RGAC_BB_MAX)
        else $error("baseband attenuation out of range");
    // request kept inside the combined limits
    a_req_limit: assert property (@(posedge clk) disable iff (rst) // RULE12
        req_r <= `RGAC_REQ_MAX)
        else $error("request beyond combined limit");
    // only the two one-hot mode codes occur
    a_mode_legal: assert property (@(posedge clk) disable iff (rst) // RULE1
        (mode_r == RGAC_MANUAL) || (mode_r == RGAC_AUTO))
        else $error("illegal mode code");

    // ==========================================================
    // checks: bus answer and register writes
    // the first cycle of every access is a wait state
    a_bus_wait: assert property (@(posedge clk) disable iff (rst) // RULE9
        s_bus_first |-> avs_waitrequest)
        else $error("first access cycle not stalled");
    // the second cycle of an access answers
    a_bus_answer: assert property (@(posedge clk) disable iff (rst) // RULE9
        s_bus_held |-> !avs_waitrequest)
        else $error("access not answered after one wait");
    // mode follows the control bit after a taken write
    a_ctrl_write: assert property (@(posedge clk) disable iff (rst) // RULE1
        s_ctrl_taken |=>
        (mode_r == RGAC_AUTO) == $past(avs_writedata[`RGAC_CTRL_AUTO_BIT]))
        else $error("mode write not applied");
    // takeover follows the written value
    a_tko_write: assert property (@(posedge clk) disable iff (rst) // RULE9
        s_tko_taken |=> takeover_r == $past(avs_writedata[5:0]))
        else $error("takeover write not applied");
    // status word carries the applied front-end setting
    a_status_read: assert property (@(posedge clk) disable iff (rst) // RULE11
        s_status_read |=>
        avs_readdata[`RGAC_ST_FE_LSB +: 5] == $past(front_end_attenuation))
        else $error("status word lacks applied front-end value");

    // ==========================================================
    // checks: request stepping
    // overload raises the request by one step
    a_over_up: assert property (@(posedge clk) disable iff (rst) // RULE12
        s_over_room |=> req_r == $past(req_r) + 6'h01)
        else $error("overload did not raise request");
    // underload alone lowers the request by one step
    a_under_down: assert property (@(posedge clk) disable iff (rst) // RULE12
        s_under_room |=> req_r == $past(req_r) - 6'h01)
        else $error("underload did not lower request");
    // manual mode leaves the request alone
    a_manual_hold: assert property (@(posedge clk) disable iff (rst) // RULE13
        (mode_r == RGAC_MANUAL) |=> $stable(req_r))
        else $error("request moved in manual mode");

    // ==========================================================
    // checks: attenuator outputs
    // manual front-end value reaches the pin
    a_manual_out: assert property (@(posedge clk) disable iff (rst) // RULE13
        s_manual_run |-> front_end_attenuation == $past(man_fe_r))
        else $error("manual front-end value not applied");
    // manual baseband value reaches the pin
    a_manual_bb: assert property (@(posedge clk) disable iff (rst) // RULE13
        s_manual_run |-> baseband_attenuation == $past(man_bb_r))
        else $error("manual baseband value not applied");
    // automatic front-end share reaches the pin
    a_auto_fe: assert property (@(posedge clk) disable iff (rst) // RULE2
        (mode_r == RGAC_AUTO) |=> front_end_attenuation == $past(split_att.fe))
        else $error("auto front-end share not applied");
    // automatic baseband share reaches the pin
    a_auto_out: assert property (@(posedge clk) disable iff (rst) // RULE2
        (mode_r == RGAC_AUTO) |=> baseband_attenuation == $past(split_att.bb))
        else $error("auto baseband share not applied");

    // ==========================================================
    // checks: split of the request
    // shares add up to the request
    a_split_sum: assert property (@(posedge clk) disable iff (rst) // RULE10
        ({1'b0, split_att.fe} + {1'b0, split_att.bb}) ==
        ((req_r > `RGAC_REQ_MAX) ? `RGAC_REQ_MAX : req_r))
        else $error("shares do not sum to request");
    // up to takeover the front end stays at zero
    a_bb_first: assert property (@(posedge clk) disable iff (rst) // RULE6
        (req_r <= takeover_r && takeover_r <= {1'b0, `RGAC_BB_MAX})
        |-> split_att.fe == 5'h00)
        else $error("front end used below takeover");
    // past takeover the front end takes the added steps
    a_fe_next: assert property (@(posedge clk) disable iff (rst) // RULE7
        (takeover_r <= {1'b0, `RGAC_BB_MAX}) && (req_r > takeover_r)
        && (req_r <= takeover_r + {1'b0, `RGAC_FE_MAX})
        |-> {1'b0, split_att.bb} == takeover_r)
        else $error("front end did not take the added steps");
    // with the front end full the rest sits on baseband
    a_bb_spill: assert property (@(posedge clk) disable iff (rst) // RULE8
        (split_att.fe == `RGAC_FE_MAX)
        |-> {1'b0, split_att.bb} == req_r - {1'b0, `RGAC_FE_MAX})
        else $error("remaining steps not on baseband");

    // ==========================================================
    // checks: downstream report
    // reported dB follows the outputs one cycle later
    a_report_db: assert property (@(posedge clk) disable iff (rst) // RULE11
        ##1 applied_atten_db == 8'(($past({3'h0, front_end_attenuation}) +
        $past({3'h0, baseband_attenuation})) * `RGAC_STEP_DB))
        else $error("reported attenuation wrong");
endmodule : rgac_top
`default_nettype wire

// file: include/rgac_map.svh
`ifndef RGAC_MAP_SVH
`define RGAC_MAP_SVH
// ==========================================================
// register offsets (byte addresses, one word each)
`define RGAC_OFF_CTRL      4'h0
`define RGAC_OFF_TAKEOVER  4'h4
`define RGAC_OFF_MANUAL    4'h8
`define RGAC_OFF_STATUS    4'hc
// ==========================================================
// field positions
`define RGAC_CTRL_AUTO_BIT 0
`define RGAC_MAN_FE_LSB    0
`define RGAC_MAN_BB_LSB    8
`define RGAC_ST_FE_LSB     0
`define RGAC_ST_BB_LSB     8
`define RGAC_ST_REQ_LSB    16
`define RGAC_ST_AUTO_BIT   24
// ==========================================================
// step limits and reset values
`define RGAC_FE_MAX        5'h12
`define RGAC_BB_MAX        5'h0f
`define RGAC_REQ_MAX       6'h21
`define RGAC_TAKEOVER_RST  6'h06
`define RGAC_STEP_DB       8'h02
`endif

// file: include/rgac_pkg.sv
// ==========================================================
// shared types of the gain/attenuation controller
package rgac_pkg;
    typedef logic [4:0] rgac_step_t;   // one attenuator, in 2 dB steps
    typedef logic [5:0] rgac_req_t;    // requested total, in steps
    // detector comparator pair
    typedef struct packed {
        logic under;                   // envelope below underload level
        logic over;                    // envelope above overload level
    } rgac_det_s;
    // split attenuation pair
    typedef struct packed {
        rgac_step_t fe;                // front-end share
        rgac_step_t bb;                // baseband share
    } rgac_att_s;
    // controller states
    typedef enum logic [1:0] {
        RGAC_MANUAL = 2'b01,
        RGAC_AUTO   = 2'b10
    } rgac_mode_e;
endpackage : rgac_pkg

// file: hw/rgac_split.sv
`timescale 1ns/1ps
`default_nettype none
`include "rgac_map.svh"
// ==========================================================
// splits a requested total into front-end and baseband shares
module rgac_split (
    // request
    input  wire rgac_pkg::rgac_req_t  req,
    input  wire rgac_pkg::rgac_req_t  takeover,
    // shares
    output var  rgac_pkg::rgac_att_s  att
);
    import rgac_pkg::*;
    rgac_req_t tk;        // takeover clipped to baseband range
    rgac_req_t fe_room;   // steps above takeover
    // ==========================================================
    // piecewise map: baseband first, then front end, then baseband
    always_comb begin
        tk = (takeover > {1'b0, `RGAC_BB_MAX}) ? {1'b0, `RGAC_BB_MAX} : takeover;
        fe_room = 6'h00;
        if (req <= tk) begin
            // first steps all on baseband
            att.fe = 5'h00;                                       // RULE6
            att.bb = req[4:0];
        end else begin
            fe_room = req - tk;
            if (fe_room <= {1'b0, `RGAC_FE_MAX}) begin
                // front end takes the added steps
                att.fe = fe_room[4:0];                            // RULE7
                att.bb = tk[4:0];
            end else begin
                // front end full, rest back on baseband
                att.fe = `RGAC_FE_MAX;                            // RULE8
                att.bb = ((req - {1'b0, `RGAC_FE_MAX}) > {1'b0, `RGAC_BB_MAX}) ?
                         `RGAC_BB_MAX : 5'((req - {1'b0, `RGAC_FE_MAX}));
            end
        end
    end
endmodule : rgac_split
`default_nettype wire

// file: test/rgac_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// analog front end: LNA detector behind the front-end attenuator, TIA detector behind both attenuators
module rgac_afe_model (
    // clock
    input  wire logic                 clk,
    // stimulus from the bench
    input  wire logic [7:0]           level,
    input  wire logic                 hold,
    // attenuator settings from the controller
    input  wire rgac_pkg::rgac_step_t fe,
    input  wire rgac_pkg::rgac_step_t bb,
    // comparator pairs
    output var  rgac_pkg::rgac_det_s  lna_det,
    output var  rgac_pkg::rgac_det_s  tia_det
);
    import rgac_pkg::*;
    int lna_env;  // envelope after the front-end attenuator
    int tia_env;  // envelope after both, with baseband gain
    // each envelope drops 2 dB for every step of the attenuators ahead of it
    always_comb begin
        lna_env = int'(level) - 2 * int'(fe);
        tia_env = lna_env - 2 * int'(bb) + 20;
    end
    // comparators start in range so no flag is unknown
    initial begin
        lna_det = '0;
        tia_det = '0;
    end
    // synchronous comparators; hold parks every flag low
    always @(posedge clk) begin
        lna_det.over  <= !hold && lna_env > 40;
        lna_det.under <= !hold && lna_env < 10;
        tia_det.over  <= !hold && tia_env > 60;
        tia_det.under <= !hold && tia_env < 30;
    end
endmodule : rgac_afe_model
`default_nettype wire

// file: test/rgac_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rgac_map.svh"
// ==========================================================
// self-checking bench with a reference model of the controller
module rgac_top_tb;
    import rgac_pkg::*;
    logic        clk = 0, rst = 1, avs_read = 0, avs_write = 0;
    logic [3:0]  avs_address = 0, avs_byteenable = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, q;
    logic        avs_waitrequest, hold = 1, go = 0;
    logic [7:0]  level = 0, applied_atten_db;
    rgac_det_s   lna_det, tia_det;
    rgac_step_t  fe_att, bb_att;
    int          n_errors = 0, compares = 0, seed = 32'h5368;
    int          auto_m, tko_m, mfe_m, mbb_m, req_m, fe_m, bb_m, db_m;
    int          tks[5] = '{0, 6, 15, 63, 0};
    logic [3:0]  addrs[5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
    always #25 clk = ~clk;
    rgac_top DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .lna_det(lna_det), .tia_det(tia_det),
        .front_end_attenuation(fe_att), .baseband_attenuation(bb_att),
        .applied_atten_db(applied_atten_db));
    rgac_afe_model u_afe (.clk(clk), .level(level), .hold(hold), .fe(fe_att), .bb(bb_att),
        .lna_det(lna_det), .tia_det(tia_det));
    // ======================================================
    // reference model
    function automatic int clip(int v, int m);
        return (v > m) ? m : v;
    endfunction : clip
    // front-end share of a request; takeover is clipped to 15
    function automatic int split_fe(int r, int t);
        int c;
        c = clip(t, 15);
        if (r <= c) return 0;
        return clip(r - c, 18);
    endfunction : split_fe
    // expected read data for each address
    function automatic int exp_rd(logic [3:0] a);
        case (a)
            `RGAC_OFF_CTRL:     return auto_m;
            `RGAC_OFF_TAKEOVER: return tko_m;
            `RGAC_OFF_MANUAL:   return clip(mfe_m, 18) | (clip(mbb_m, 15) << 8);
            `RGAC_OFF_STATUS:   return fe_m | (bb_m << 8) | (req_m << 16) | (auto_m << 24);
            default:            return 0;
        endcase
    endfunction : exp_rd
    // model state follows accepted writes and detector flags
    always @(posedge clk) begin
        if (rst) begin
            {auto_m, mfe_m, mbb_m, req_m, fe_m, bb_m, db_m} <= '0;
            tko_m <= 6;
        end else begin
            if (avs_write && !avs_waitrequest) begin
                case (avs_address)
                    `RGAC_OFF_CTRL:     if (avs_byteenable[0]) auto_m <= avs_writedata[0];
                    `RGAC_OFF_TAKEOVER: if (avs_byteenable[0]) tko_m <= avs_writedata[5:0];
                    `RGAC_OFF_MANUAL: begin
                        if (avs_byteenable[0]) mfe_m <= avs_writedata[4:0];
                        if (avs_byteenable[1]) mbb_m <= avs_writedata[12:8];
                    end
                    default: ;
                endcase
            end
            // overload wins, underload needs both pairs
            if (auto_m != 0) begin
                if (lna_det.over || tia_det.over) req_m <= clip(req_m + 1, 33);
                else if (lna_det.under && tia_det.under && req_m > 0) req_m <= req_m - 1;
            end
            fe_m <= auto_m ? split_fe(req_m, tko_m) : clip(mfe_m, 18);
            bb_m <= auto_m ? req_m - split_fe(req_m, tko_m) : clip(mbb_m, 15);
            db_m <= 2 * (fe_m + bb_m);
        end
    end
    // ======================================================
    // compare, bus and closing tasks
    task check(input string what, input logic [31:0] got, input int exp);
        compares++;
        if (got !== 32'(exp)) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : check
    // one avalon access: hold until waitrequest is seen low
    task bus(input logic [3:0] a, input logic wr, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= d;
        avs_byteenable <= be;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        q = avs_readdata;
        avs_read  <= 0;
        avs_write <= 0;
        check("wait states", n, 1);
        @(posedge clk);
    endtask : bus
    // park detectors, then read every address and a hole
    task read_all();
        hold <= 1;
        repeat (6) @(posedge clk);
        foreach (addrs[i]) begin
            bus(addrs[i], 0, 0, 4'hf);
            check("read", q, exp_rd(addrs[i]));
        end
        hold <= 0;
    endtask : read_all
    task tally_and_finish();
        if (n_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    // ports match the model on every cycle
    always @(negedge clk) begin
        if (go) begin
            check("front end", fe_att, fe_m);
            check("baseband", bb_att, bb_m);
            check("applied db", applied_atten_db, db_m);
        end
    end
    // ======================================================
    // watchdog
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        $display("CHECK FAILED at %0t: timeout", $time);
        tally_and_finish();
    end
    // main sequence
    initial begin
        @(posedge clk);
        go = 1;
        repeat (11) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        read_all();
        bus(`RGAC_OFF_TAKEOVER, 1, 32'h3f, 4'h0);
        // manual mode with live detectors and clipped values
        repeat (6) begin
            bus(`RGAC_OFF_MANUAL, 1, $random(seed), 4'($random(seed)));
            level <= 8'($random(seed));
            repeat (10) @(posedge clk);
        end
        read_all();
        tks[4] = $random(seed) & 63;
        // automatic mode across takeover thresholds
        foreach (tks[i]) begin
            bus(`RGAC_OFF_TAKEOVER, 1, tks[i], 4'h1);
            bus(`RGAC_OFF_CTRL, 1, 1, 4'h1);
            level <= 8'hff;
            repeat (50) @(posedge clk);
            read_all();
            level <= 8'h00;
            repeat (50) @(posedge clk);
            read_all();
            level <= 8'($random(seed));
            repeat (30) @(posedge clk);
            bus(`RGAC_OFF_CTRL, 1, 0, 4'h1);
            repeat (10) @(posedge clk);
            bus(`RGAC_OFF_CTRL, 1, 1, 4'h1);
            repeat (20) @(posedge clk);
            read_all();
        end
        tally_and_finish();
    end
endmodule : rgac_top_tb
`default_nettype wire
